// file: hw/limit_comparator.sv
`timescale 1ns/100ps
module limit_comparator (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        soft_clear,
  input  wire logic        hysteresis_sel,
  input  wire logic        read_clear,
  input  wire logic        conv_done,
  input  wire logic [13:0] result,
  input  wire logic [13:0] high_limit,
  input  wire logic [13:0] low_limit,
  output logic             upper_flag,
  output logic             lower_flag
);
  typedef struct packed {
    logic upper;
    logic lower;
  } cmp_state_t;

  cmp_state_t state;
  cmp_state_t next_state;
  logic       above;
  logic       below;

  assign above      = $signed(result) > $signed(high_limit);
  assign below      = $signed(result) < $signed(low_limit);
  assign upper_flag = state.upper;
  assign lower_flag = state.lower;

  always_comb begin
    next_state = state;
    if (soft_clear) begin
      next_state = '0;
    end else if (hysteresis_sel) begin
      next_state.lower = 1'b0;
      if (conv_done && above) begin
        next_state.upper = 1'b1;
      end else if (conv_done && below) begin
        next_state.upper = 1'b0;
      end
    end else begin
      if (read_clear) begin
        next_state = '0;
      end
      if (conv_done && above) begin
        next_state.upper = 1'b1;
      end
      if (conv_done && below) begin
        next_state.lower = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  AST_HYST_NO_READ_CLEAR: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && hysteresis_sel && !soft_clear && !conv_done && state.upper |=> state.upper)
    else $error("hysteresis flag cleared outside a conversion end");
  AST_HYST_LOWER_ZERO: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && hysteresis_sel |=> !state.lower)
    else $error("lower flag set in hysteresis mode");
  AST_WINDOW_SET: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && !soft_clear && !hysteresis_sel && conv_done && above |=> state.upper)
    else $error("window upper flag not set");
endmodule

// file: hw/temp_sensor_config_alert_logic.sv
`timescale 1ns/100ps
module temp_sensor_config_alert_logic (
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  input  wire logic                   clk_en,
  input  wire logic                   reg_write,
  input  wire logic                   reg_read,
  input  wire logic [3:0]             reg_addr,
  input  wire logic [15:0]            reg_wdata,
  input  wire logic                   nvm_unlock_state,
  input  wire tsc_pkg::sample_t       sample,
  input  wire tsc_pkg::limits_t       limits_a,
  input  wire tsc_pkg::limits_t       limits_b,
  output logic [15:0]                 reg_rdata,
  output logic                        conv_start,
  output logic                        conv_active,
  output logic                        nvm_busy,
  output logic                        nvm_write,
  output logic [15:0]                 nvm_wdata,
  output logic                        soft_reset,
  output logic                        trip_output_pin_a,
  output logic                        trip_output_pin_b
);
  localparam longint CONV_CYC_L = longint'(tsc_pkg::CONV_MS) * tsc_pkg::CYC_PER_MS;
  localparam longint NVM_CYC_L  = longint'(tsc_pkg::NVM_PROG_MS) * tsc_pkg::CYC_PER_MS;
  localparam logic [31:0] PER_CYC [8] = '{
    32'(longint'(tsc_pkg::PERIOD_MS_0) * tsc_pkg::CYC_PER_MS),
    32'(longint'(tsc_pkg::PERIOD_MS_1) * tsc_pkg::CYC_PER_MS),
    32'(longint'(tsc_pkg::PERIOD_MS_2) * tsc_pkg::CYC_PER_MS),
    32'(longint'(tsc_pkg::PERIOD_MS_3) * tsc_pkg::CYC_PER_MS),
    32'(longint'(tsc_pkg::PERIOD_MS_4) * tsc_pkg::CYC_PER_MS),
    32'(longint'(tsc_pkg::PERIOD_MS_5) * tsc_pkg::CYC_PER_MS),
    32'(longint'(tsc_pkg::PERIOD_MS_6) * tsc_pkg::CYC_PER_MS),
    32'(longint'(tsc_pkg::PERIOD_MS_7) * tsc_pkg::CYC_PER_MS)
  };

  parameter logic [31:0] CONV_CYCLES = 32'(CONV_CYC_L);
  parameter logic [31:0] NVM_CYCLES  = 32'(NVM_CYC_L);
  parameter logic [31:0] PERIOD_DIV  = 32'h1;

  typedef struct packed {
    tsc_pkg::ctrl_t       ctrl;
    tsc_pkg::conv_state_t fsm;
    logic [31:0]          conv_cnt;
    logic [31:0]          period_cnt;
    logic                 single_run;
    logic                 unlock_s1;
    logic                 unlock_s2;
    logic [15:0]          rdata;
    logic                 start;
    logic                 nvm_wr;
    logic [15:0]          nvm_data;
    logic                 restart;
  } top_state_t;

  top_state_t  state;
  top_state_t  next_state;
  logic        cfg_wr;
  logic        cfg_rd;
  logic        conv_done;
  logic        upper_a;
  logic        lower_a;
  logic        upper_b;
  logic        lower_b;
  logic [15:0] cfg_view;
  logic [31:0] period_len;

  assign cfg_wr     = reg_write && reg_addr == tsc_pkg::REG_OPERATING_CONTROL
                      && state.fsm != tsc_pkg::ST_NVM;
  assign cfg_rd     = reg_read && reg_addr == tsc_pkg::REG_OPERATING_CONTROL;
  assign conv_done  = sample.valid && state.fsm == tsc_pkg::ST_CONVERT;
  assign period_len = PER_CYC[state.ctrl.conversion_rate_sel] / PERIOD_DIV;

  always_comb begin
    cfg_view                         = '0;
    cfg_view[tsc_pkg::POS_RATE_HI:tsc_pkg::POS_RATE_LO] = state.ctrl.conversion_rate_sel;
    cfg_view[tsc_pkg::POS_SINGLE]    = 1'b0;
    cfg_view[tsc_pkg::POS_SHUTDOWN]  = state.ctrl.shutdown_select;
    cfg_view[tsc_pkg::POS_UPPER_A]   = upper_a;
    cfg_view[tsc_pkg::POS_LOWER_A]   = lower_a;
    cfg_view[tsc_pkg::POS_MODE_A]    = state.ctrl.window_or_hysteresis_sel_a;
    cfg_view[tsc_pkg::POS_SENSE_A]   = state.ctrl.trip_out_sense_a;
    cfg_view[tsc_pkg::POS_UPPER_B]   = upper_b;
    cfg_view[tsc_pkg::POS_LOWER_B]   = lower_b;
    cfg_view[tsc_pkg::POS_MODE_B]    = state.ctrl.window_or_hysteresis_sel_b;
    cfg_view[tsc_pkg::POS_SENSE_B]   = state.ctrl.trip_out_sense_b;
    cfg_view[0]                      = state.ctrl.reserved_bit0;
  end

  always_comb begin
    next_state           = state;
    next_state.start     = 1'b0;
    next_state.nvm_wr    = 1'b0;
    next_state.restart   = 1'b0;
    next_state.unlock_s1 = nvm_unlock_state;
    next_state.unlock_s2 = state.unlock_s1;
    if (cfg_rd) begin
      next_state.rdata = cfg_view;
    end
    case (state.fsm)
      tsc_pkg::ST_IDLE: begin
        if (!state.ctrl.shutdown_select) begin
          next_state.fsm        = tsc_pkg::ST_CONVERT;
          next_state.start      = 1'b1;
          next_state.conv_cnt   = '0;
          next_state.period_cnt = '0;
        end
      end
      tsc_pkg::ST_CONVERT: begin
        next_state.conv_cnt   = state.conv_cnt + 32'h1;
        next_state.period_cnt = state.period_cnt + 32'h1;
        if (sample.valid || state.conv_cnt >= CONV_CYCLES) begin
          if (state.single_run || state.ctrl.shutdown_select) begin
            next_state.single_run = 1'b0;
            next_state.fsm        = tsc_pkg::ST_IDLE;
          end else begin
            next_state.fsm = tsc_pkg::ST_WAIT;
          end
        end
      end
      tsc_pkg::ST_WAIT: begin
        next_state.period_cnt = state.period_cnt + 32'h1;
        if (state.period_cnt + 32'h1 >= period_len) begin
          next_state.fsm        = tsc_pkg::ST_CONVERT;
          next_state.start      = 1'b1;
          next_state.conv_cnt   = '0;
          next_state.period_cnt = '0;
        end
      end
      tsc_pkg::ST_NVM: begin
        next_state.conv_cnt = state.conv_cnt + 32'h1;
        if (state.conv_cnt + 32'h1 >= NVM_CYCLES) begin
          next_state.fsm = tsc_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state.fsm = tsc_pkg::ST_IDLE;
      end
    endcase
    if (cfg_wr) begin
      if (reg_wdata[tsc_pkg::POS_SOFT_RESTART]) begin
        next_state.restart    = 1'b1;
        next_state.ctrl       = tsc_pkg::ctrl_t'({tsc_pkg::RATE_RESET, 5'h00, 1'b0});
        next_state.fsm        = tsc_pkg::ST_IDLE;
        next_state.single_run = 1'b0;
        next_state.rdata      = '0;
      end else if (state.unlock_s2) begin
        next_state.nvm_wr   = 1'b1;
        next_state.nvm_data = reg_wdata & ~(16'h1 << tsc_pkg::POS_SINGLE);
        next_state.fsm      = tsc_pkg::ST_NVM;
        next_state.conv_cnt = '0;
      end else begin
        next_state.ctrl.conversion_rate_sel =
          reg_wdata[tsc_pkg::POS_RATE_HI:tsc_pkg::POS_RATE_LO];
        next_state.ctrl.shutdown_select            = reg_wdata[tsc_pkg::POS_SHUTDOWN];
        next_state.ctrl.window_or_hysteresis_sel_a = reg_wdata[tsc_pkg::POS_MODE_A];
        next_state.ctrl.trip_out_sense_a           = reg_wdata[tsc_pkg::POS_SENSE_A];
        next_state.ctrl.window_or_hysteresis_sel_b = reg_wdata[tsc_pkg::POS_MODE_B];
        next_state.ctrl.trip_out_sense_b           = reg_wdata[tsc_pkg::POS_SENSE_B];
        next_state.ctrl.reserved_bit0              = reg_wdata[0];
        next_state.fsm        = tsc_pkg::ST_IDLE;
        next_state.single_run = 1'b0;
        if (reg_wdata[tsc_pkg::POS_SHUTDOWN] && reg_wdata[tsc_pkg::POS_SINGLE]) begin
          next_state.fsm        = tsc_pkg::ST_CONVERT;
          next_state.single_run = 1'b1;
          next_state.start      = 1'b1;
          next_state.conv_cnt   = '0;
          next_state.period_cnt = '0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state      <= '0;
      state.ctrl <= tsc_pkg::ctrl_t'({tsc_pkg::RATE_RESET, 5'h00, 1'b0});
      state.fsm  <= tsc_pkg::ST_IDLE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  limit_comparator u_cmp_a (
    .clk_sys        (clk_sys),
    .reset_n        (reset_n),
    .clk_en         (clk_en),
    .soft_clear     (state.restart),
    .hysteresis_sel (state.ctrl.window_or_hysteresis_sel_a),
    .read_clear     (cfg_rd),
    .conv_done      (conv_done),
    .result         (sample.value),
    .high_limit     (limits_a.high),
    .low_limit      (limits_a.low),
    .upper_flag     (upper_a),
    .lower_flag     (lower_a)
  );

  limit_comparator u_cmp_b (
    .clk_sys        (clk_sys),
    .reset_n        (reset_n),
    .clk_en         (clk_en),
    .soft_clear     (state.restart),
    .hysteresis_sel (state.ctrl.window_or_hysteresis_sel_b),
    .read_clear     (cfg_rd),
    .conv_done      (conv_done),
    .result         (sample.value),
    .high_limit     (limits_b.high),
    .low_limit      (limits_b.low),
    .upper_flag     (upper_b),
    .lower_flag     (lower_b)
  );

  trip_pin_driver u_pin_a (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .clk_en     (clk_en),
    .upper_flag (upper_a),
    .lower_flag (lower_a),
    .sense      (state.ctrl.trip_out_sense_a),
    .pin        (trip_output_pin_a)
  );

  trip_pin_driver u_pin_b (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .clk_en     (clk_en),
    .upper_flag (upper_b),
    .lower_flag (lower_b),
    .sense      (state.ctrl.trip_out_sense_b),
    .pin        (trip_output_pin_b)
  );

  assign reg_rdata   = state.rdata;
  assign conv_start  = state.start;
  assign conv_active = state.fsm[1];
  assign nvm_busy    = state.fsm[3];
  assign nvm_write   = state.nvm_wr;
  assign nvm_wdata   = state.nvm_data;
  assign soft_reset  = state.restart;

  AST_READ_OS_ZERO: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !reg_rdata[tsc_pkg::POS_SINGLE])
    else $error("single trigger bit read as one");
  AST_WRITE_ABORTS: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && cfg_wr && !state.unlock_s2 && !reg_wdata[tsc_pkg::POS_SINGLE]
    |=> !conv_active)
    else $error("conversion not aborted by write");
  AST_SHUTDOWN_STAYS: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && state.ctrl.shutdown_select && state.fsm == tsc_pkg::ST_IDLE && !cfg_wr
    |=> !conv_start)
    else $error("conversion started in shutdown");
  AST_NVM_NO_STORE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && cfg_wr && state.unlock_s2 && !reg_wdata[tsc_pkg::POS_SOFT_RESTART]
    |=> nvm_write && nvm_busy && state.ctrl == $past(state.ctrl))
    else $error("nonvolatile write mishandled");
  AST_VOLATILE_STORE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && cfg_wr && !state.unlock_s2 && !reg_wdata[tsc_pkg::POS_SOFT_RESTART]
    |=> state.ctrl.conversion_rate_sel == $past(reg_wdata[15:13]) && !nvm_write)
    else $error("volatile write not stored");
  AST_SOFT_RESTART: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && cfg_wr && reg_wdata[tsc_pkg::POS_SOFT_RESTART]
    |=> soft_reset && state.ctrl.conversion_rate_sel == tsc_pkg::RATE_RESET)
    else $error("soft restart ignored");

  AST_NVM_WRITE_DROPPED: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && reg_write && reg_addr == tsc_pkg::REG_OPERATING_CONTROL && nvm_busy
    |=> state.ctrl == $past(state.ctrl) && !nvm_write)
    else $error("write accepted while programming");
  AST_SINGLE_START: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && cfg_wr && !state.unlock_s2 && !reg_wdata[tsc_pkg::POS_SOFT_RESTART]
    && reg_wdata[tsc_pkg::POS_SHUTDOWN] && reg_wdata[tsc_pkg::POS_SINGLE]
    |=> conv_start && conv_active)
    else $error("single conversion not started");
  AST_SINGLE_RETURNS: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && conv_done && state.ctrl.shutdown_select && !cfg_wr |=> !conv_active)
    else $error("no return to shutdown after single conversion");
  AST_CONT_START: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && state.fsm == tsc_pkg::ST_IDLE && !state.ctrl.shutdown_select && !cfg_wr
    |=> conv_start && conv_active)
    else $error("continuous conversion not started");
  AST_RATE_RESTART: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && cfg_wr && !state.unlock_s2 && !reg_wdata[tsc_pkg::POS_SOFT_RESTART]
    && !reg_wdata[tsc_pkg::POS_SHUTDOWN]
    && reg_wdata[15:13] != state.ctrl.conversion_rate_sel
    |=> clk_en && !cfg_wr |=> conv_start)
    else $error("no fresh conversion after rate change");
  AST_SHUTDOWN_ABORT: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && cfg_wr && !state.unlock_s2 && reg_wdata[tsc_pkg::POS_SHUTDOWN]
    && !reg_wdata[tsc_pkg::POS_SINGLE] |=> !conv_active && !conv_start)
    else $error("shutdown not immediate");
  AST_READ_RATE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && cfg_rd && !cfg_wr
    |=> reg_rdata[15:13] == $past(state.ctrl.conversion_rate_sel))
    else $error("rate field read wrong");
  AST_READ_SHUTDOWN: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && cfg_rd && !cfg_wr
    |=> reg_rdata[tsc_pkg::POS_SHUTDOWN] == $past(state.ctrl.shutdown_select))
    else $error("shutdown bit read wrong");
  AST_MODE_STORE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && cfg_wr && !state.unlock_s2 && !reg_wdata[tsc_pkg::POS_SOFT_RESTART]
    |=> state.ctrl.window_or_hysteresis_sel_b == $past(reg_wdata[tsc_pkg::POS_MODE_B])
    && state.ctrl.trip_out_sense_b == $past(reg_wdata[tsc_pkg::POS_SENSE_B]))
    else $error("comparator two mode not stored");
  AST_RESTART_FLAGS: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && soft_reset
    |=> !upper_a && !lower_a && !upper_b && !lower_b)
    else $error("flags kept over soft restart");
  AST_READ_FLAG_A: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && cfg_rd && !cfg_wr
    |=> reg_rdata[tsc_pkg::POS_UPPER_A] == $past(upper_a))
    else $error("upper flag a read wrong");
endmodule

// file: hw/trip_pin_driver.sv
`timescale 1ns/100ps
module trip_pin_driver (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic clk_en,
  input  wire logic upper_flag,
  input  wire logic lower_flag,
  input  wire logic sense,
  output logic      pin
);
  typedef struct packed {
    logic level;
  } pin_state_t;

  pin_state_t state;
  pin_state_t next_state;

  assign pin = state.level;

  always_comb begin
    next_state       = state;
    next_state.level = (upper_flag | lower_flag) ? sense : ~sense;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= '{level: 1'b1};
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  AST_PIN_LEVEL: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en |=> pin == (($past(upper_flag) | $past(lower_flag)) ? $past(sense) : ~$past(sense)))
    else $error("trip pin level wrong");
endmodule

// file: hw/tsc_pkg.sv
package tsc_pkg;
  localparam logic [3:0]  REG_OPERATING_CONTROL = 4'h1;
  localparam logic [15:0] CTRL_RESET            = 16'hA000;
  localparam int          POS_RATE_HI           = 15;
  localparam int          POS_RATE_LO           = 13;
  localparam int          POS_SINGLE            = 12;
  localparam int          POS_SHUTDOWN          = 11;
  localparam int          POS_UPPER_A           = 10;
  localparam int          POS_LOWER_A           = 9;
  localparam int          POS_MODE_A            = 8;
  localparam int          POS_SENSE_A           = 7;
  localparam int          POS_UPPER_B           = 6;
  localparam int          POS_LOWER_B           = 5;
  localparam int          POS_MODE_B            = 4;
  localparam int          POS_SENSE_B           = 3;
  localparam int          POS_SOFT_RESTART      = 1;
  localparam logic [2:0]  RATE_RESET            = 3'h5;
  localparam int          CLK_MHZ               = 125;
  localparam int          NVM_PROG_MS           = 16;
  localparam int          PERIOD_MS_0           = 15;
  localparam int          PERIOD_MS_1           = 50;
  localparam int          PERIOD_MS_2           = 100;
  localparam int          PERIOD_MS_3           = 250;
  localparam int          PERIOD_MS_4           = 500;
  localparam int          PERIOD_MS_5           = 1000;
  localparam int          PERIOD_MS_6           = 4000;
  localparam int          PERIOD_MS_7           = 16000;
  localparam int          CONV_MS               = 15;
  localparam longint      CYC_PER_MS            = longint'(CLK_MHZ) * 1000;

  typedef struct packed {
    logic [2:0] conversion_rate_sel;
    logic       shutdown_select;
    logic       window_or_hysteresis_sel_a;
    logic       trip_out_sense_a;
    logic       window_or_hysteresis_sel_b;
    logic       trip_out_sense_b;
    logic       reserved_bit0;
  } ctrl_t;

  typedef struct packed {
    logic        valid;
    logic [13:0] value;
  } sample_t;

  typedef struct packed {
    logic        valid;
    logic [13:0] high;
    logic [13:0] low;
  } limits_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_CONVERT = 4'b0010,
    ST_WAIT    = 4'b0100,
    ST_NVM     = 4'b1000
  } conv_state_t;
endpackage

// file: sim/sensor_frontend_model.sv
`timescale 1ns/100ps
module sensor_frontend_model (
  input  wire logic        clk_sys,
  input  wire logic        conv_start,
  input  wire logic [13:0] temp_value,
  input  wire logic [7:0]  conv_delay,
  output tsc_pkg::sample_t sample
);
  int          countdown = 0;
  logic [13:0] last      = 14'h0000;
  initial begin
    sample = '0;
  end
  // one result per started conversion; a new start restarts the count
  // result shows only at conversion end, otherwise the inverse of the last result
  always @(posedge clk_sys) begin
    sample.valid <= 1'b0;
    sample.value <= ~last;
    if (conv_start) begin
      countdown <= int'(conv_delay);
    end else if (countdown == 1) begin
      countdown    <= 0;
      sample.valid <= 1'b1;
      sample.value <= temp_value;
      last         <= temp_value;
    end else if (countdown > 1) begin
      countdown <= countdown - 1;
    end
  end
endmodule

// file: sim/temp_sensor_config_alert_logic_bench.sv
`timescale 1ns/100ps
module temp_sensor_config_alert_logic_bench;
  logic             clk_sys          = 1'b0;
  logic             reset_n          = 1'b0;
  logic             reg_write        = 1'b0;
  logic             reg_read         = 1'b0;
  logic [3:0]       reg_addr         = 4'h0;
  logic [15:0]      reg_wdata        = 16'h0000;
  logic             nvm_unlock_state = 1'b0;
  logic [13:0]      temp_value       = 14'h0032;
  tsc_pkg::limits_t limits_a         = {1'b1, 14'h0064, 14'h000A};
  tsc_pkg::limits_t limits_b         = {1'b1, 14'h1FFF, 14'h2000};
  tsc_pkg::sample_t sample;
  logic [15:0]      reg_rdata;
  logic [15:0]      nvm_wdata;
  logic             conv_start, conv_active, nvm_busy, nvm_write, soft_reset, pin_a, pin_b;
  int               num_errors       = 0;
  int               checks           = 0;
  int               cyc              = 0;
  int               n;

  always #4 clk_sys = ~clk_sys;

  temp_sensor_config_alert_logic #(
    .CONV_CYCLES(32'h14), .NVM_CYCLES(32'h1E), .PERIOD_DIV(32'h186A0)
  ) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1),
    .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .nvm_unlock_state(nvm_unlock_state), .sample(sample),
    .limits_a(limits_a), .limits_b(limits_b), .reg_rdata(reg_rdata),
    .conv_start(conv_start), .conv_active(conv_active), .nvm_busy(nvm_busy),
    .nvm_write(nvm_write), .nvm_wdata(nvm_wdata), .soft_reset(soft_reset),
    .trip_output_pin_a(pin_a), .trip_output_pin_b(pin_b)
  );

  sensor_frontend_model fe (
    .clk_sys(clk_sys), .conv_start(conv_start), .temp_value(temp_value),
    .conv_delay(8'h0F), .sample(sample)
  );

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: pick = conv_start;
      1: pick = !conv_active;
      2: pick = nvm_write;
      3: pick = !nvm_busy;
      default: pick = soft_reset;
    endcase
  endfunction

  task automatic wait_on(input int w, input int lim, output int k);
    k = 0;
    while (pick(w) !== 1'b1 && k < lim) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
  endtask

  task automatic step(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    step(1);
    reg_write = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    step(1);
    reg_write = 1'b0;
  endtask

  task automatic rd(input string what, input logic [15:0] exp);
    step(1);
    reg_read = 1'b1;
    reg_addr = 4'h1;
    step(1);
    reg_read = 1'b0;
    chk(what, exp, reg_rdata);
  endtask

  task automatic conv(input logic [13:0] v, input logic [15:0] w);
    int k;
    temp_value = v;
    wr(4'h1, w | 16'h1000);
    wait_on(0, 5, k);
    chk("single start", 1, k < 5);
    wait_on(1, 40, k);
    wait_on(0, 30, k);
    chk("back to shutdown", 1, k == 30);
  endtask

  task automatic t_reg;
    rd("ctrl reset", 16'hA000);
    wr(4'h2, 16'h0000);
    rd("ctrl other addr", 16'hA000);
    $display("test reg finished");
  endtask

  task automatic t_window;
    wr(4'h1, 16'h0800);
    step(2);
    chk("active after shutdown", 0, conv_active);
    conv(14'h00C8, 16'h0800);
    chk("pin a low", 0, pin_a);
    rd("upper flag a", 16'h0C00);
    rd("flag a cleared", 16'h0800);
    step(2);
    chk("pin a idle", 1, pin_a);
    conv(14'h0005, 16'h0880);
    chk("pin a high", 1, pin_a);
    rd("lower flag a", 16'h0A80);
    rd("trigger reads 0", 16'h0880);
    $display("test window finished");
  endtask

  task automatic t_hyst;
    limits_b = limits_a;
    limits_a = {1'b1, 14'h1FFF, 14'h2000};
    conv(14'h00C8, 16'h0818);
    chk("pin b high", 1, pin_b);
    rd("upper flag b", 16'h0858);
    rd("hyst flag kept", 16'h0858);
    conv(14'h0032, 16'h0818);
    rd("hyst between", 16'h0858);
    conv(14'h0005, 16'h0818);
    rd("hyst cleared", 16'h0818);
    chk("pin b idle", 0, pin_b);
    $display("test hyst finished");
  endtask

  task automatic t_rate;
    temp_value = 14'h0032;
    wr(4'h1, 16'h0000);
    wait_on(0, 40, n);
    step(1);
    wait_on(0, 40, n);
    chk("rate 0 period", 1, n >= 16 && n <= 19);
    step(5);
    wr(4'h1, 16'h2000);
    wait_on(0, 4, n);
    chk("restart on rate", 1, n < 4);
    step(1);
    wait_on(0, 100, n);
    chk("rate 1 period", 1, n >= 59 && n <= 63);
    $display("test rate finished");
  endtask

  task automatic t_nvm;
    wr(4'h1, 16'h0800);
    nvm_unlock_state = 1'b1;
    step(3);
    wr(4'h1, 16'h1880);
    wait_on(2, 4, n);
    chk("nvm pulse", 1, n < 4);
    chk("nvm word", 16'h0880, nvm_wdata);
    step(1);
    chk("nvm busy", 1, nvm_busy);
    wr(4'h1, 16'h0000);
    wait_on(3, 60, n);
    chk("busy time", 1, n >= 20 && n < 60);
    step(3);
    chk("write dropped", 0, conv_active);
    nvm_unlock_state = 1'b0;
    step(3);
    $display("test nvm finished");
  endtask

  task automatic t_restart;
    wr(4'h1, 16'h0002);
    wait_on(4, 4, n);
    chk("soft reset pulse", 1, n < 4);
    step(3);
    rd("ctrl restored", 16'hA000);
    $display("test restart finished");
  endtask

  initial begin
    step(5);
    reset_n = 1'b1;
    t_reg();
    t_window();
    t_hyst();
    t_rate();
    t_nvm();
    t_restart();
    test_done();
  end
endmodule
